// ---- common/oat_pkg.sv ----
package oat_pkg;
  // ---------------------------------------------------------------
  // Addressing modes
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    oat_m_abs, oat_m_abs_ind_x, oat_m_abs_x, oat_m_abs_y, oat_m_abs_ind,
    oat_m_acc, oat_m_imm, oat_m_impl, oat_m_rel, oat_m_stack,
    oat_m_zp, oat_m_zp_ind_x, oat_m_zp_x, oat_m_zp_y, oat_m_zp_ind,
    oat_m_zp_ind_y, oat_m_break
  } oat_mode_t;

  // ---------------------------------------------------------------
  // Base cycle counts per mode, and cycles added on top of them
  // ---------------------------------------------------------------
  localparam logic [3:0] CYC_ABS = 4'h4;
  localparam logic [3:0] CYC_ABS_IND_X = 4'h6;
  localparam logic [3:0] CYC_ABS_IND = 4'h6;
  localparam logic [3:0] CYC_TWO = 4'h2;
  localparam logic [3:0] CYC_ZP = 4'h3;
  localparam logic [3:0] CYC_ZP_IND_X = 4'h6;
  localparam logic [3:0] CYC_ZP_X = 4'h4;
  localparam logic [3:0] CYC_ZP_Y = 4'h4;
  localparam logic [3:0] CYC_ZP_IND = 4'h5;
  localparam logic [3:0] CYC_ZP_IND_Y = 4'h5;
  localparam logic [3:0] CYC_BREAK = 4'h7;
  localparam logic [3:0] CYC_ONE = 4'h1;
  localparam logic [3:0] CYC_RMW = 4'h2;

  // ---------------------------------------------------------------
  // Instruction lengths
  // ---------------------------------------------------------------
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  // Page zero high byte and pointer step
  localparam logic [7:0] PAGE_ZERO = 8'h00;
  localparam logic [7:0] PTR_STEP = 8'h01;
endpackage : oat_pkg

// ---- design/oat_add8.sv ----
`timescale 1ns/10ps
// Registered 8-bit adder: sum and carry out, used for index and pointer math
module oat_add8 (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  // Registered result
  output logic [7:0] sum_r,
  output logic carry_r
);
  // ---------------------------------------------------------------
  // Sum register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sum_r <= 8'h00;
      carry_r <= 1'b0;
    end else begin
      {carry_r, sum_r} <= {1'b0, a} + {1'b0, b};
    end
  end
endmodule : oat_add8

// ---- design/oat_top.sv ----
`timescale 1ns/10ps
// What this block does
// - zp,x low byte is zp plus X, high zero
// - zp,y sum of zp and Y stays page zero
// - (zp) reads pointer low then high byte
// - (zp),y base from page zero plus Y
// - absolute forms take 4 cycles, 3 bytes
// - indexed indirect jump takes 6 cycles, 3 bytes
// - absolute indirect jump takes 6 cycles, 3 bytes
// - relative branch takes 2 cycles, 2 bytes
// - (zp,x) takes 6 cycles, 2 bytes
// - zp,x takes 4 cycles, 2 bytes, plus RMW
// - zp,y takes 4 cycles, 2 bytes
// - (zp) takes 5 cycles, 2 bytes
// - (zp),y takes 5 cycles plus page crossing
// - index carry into high byte adds cycle
// - store accumulator abs,x always adds cycle
// - taken branch adds one cycle, one more if it crosses a page
// - read-modify-write adds two cycles
// - break is two bytes, PC advances twice
// - return after break skips signature byte
module oat_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Instruction request
  input wire logic start,
  input wire oat_pkg::oat_mode_t mode,
  input wire logic [7:0] operand_lo,
  input wire logic [7:0] operand_hi,
  input wire logic [7:0] index_x,
  input wire logic [7:0] index_y,
  input wire logic [15:0] pc_opcode,
  input wire logic is_rmw,
  input wire logic is_store_accumulator,
  input wire logic branch_taken,
  // Memory read data for pointer fetches
  input wire logic [7:0] mem_rdata,
  // Memory address out
  output logic [15:0] mem_addr_r,
  output logic mem_rd_r,
  // Results
  output logic done_r,
  output logic busy_r,
  output logic [15:0] eff_addr_r,
  output logic [3:0] cycles_r,
  output logic [1:0] length_r,
  output logic [15:0] next_pc_r,
  output logic [15:0] return_pc_r
);
  // ---------------------------------------------------------------
  // State and holding registers
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    oat_s_idle, oat_s_index, oat_s_ptr_lo, oat_s_ptr_hi, oat_s_post, oat_s_finish
  } oat_state_t;

  oat_state_t state_r; // Sequencer state
  oat_pkg::oat_mode_t mode_r; // Mode held for the instruction
  logic [7:0] zp_r; // Page zero byte or pointer
  logic [7:0] hi_r; // Operand high byte
  logic [7:0] x_r; // Captured X
  logic [7:0] y_r; // Captured Y
  logic [7:0] ptr_lo_r; // Fetched pointer low byte
  logic [15:0] pc_r; // Opcode address
  logic rmw_r; // Read-modify-write flag
  logic sta_r; // Store accumulator flag
  logic taken_r; // Branch taken flag
  logic [3:0] base_cyc; // Base cycles of the mode
  logic [1:0] base_len; // Byte count of the mode
  logic [7:0] add_a; // Adder operand a
  logic [7:0] add_b; // Adder operand b
  logic [7:0] add_sum; // Registered sum
  logic add_carry; // Registered carry into high byte
  logic [15:0] eff_nxt; // Final effective address
  logic [3:0] cyc_nxt; // Final cycle count
  logic [15:0] br_target; // Branch destination
  logic br_cross; // Branch moves into another page

  // ---------------------------------------------------------------
  // Base timing per mode
  // ---------------------------------------------------------------
  always_comb begin
    base_cyc = oat_pkg::CYC_TWO;
    base_len = oat_pkg::LEN_ONE;
    case (mode_r)
      oat_pkg::oat_m_abs, oat_pkg::oat_m_abs_x, oat_pkg::oat_m_abs_y: begin
        base_cyc = oat_pkg::CYC_ABS;
        base_len = oat_pkg::LEN_THREE;
      end
      oat_pkg::oat_m_abs_ind_x: begin
        base_cyc = oat_pkg::CYC_ABS_IND_X;
        base_len = oat_pkg::LEN_THREE;
      end
      oat_pkg::oat_m_abs_ind: begin
        base_cyc = oat_pkg::CYC_ABS_IND;
        base_len = oat_pkg::LEN_THREE;
      end
      oat_pkg::oat_m_rel: begin
        base_cyc = oat_pkg::CYC_TWO;
        base_len = oat_pkg::LEN_TWO;
      end
      oat_pkg::oat_m_imm: begin
        base_cyc = oat_pkg::CYC_TWO;
        base_len = oat_pkg::LEN_TWO;
      end
      oat_pkg::oat_m_zp: begin
        base_cyc = oat_pkg::CYC_ZP;
        base_len = oat_pkg::LEN_TWO;
      end
      oat_pkg::oat_m_zp_ind_x: begin
        base_cyc = oat_pkg::CYC_ZP_IND_X;
        base_len = oat_pkg::LEN_TWO;
      end
      oat_pkg::oat_m_zp_x: begin
        base_cyc = oat_pkg::CYC_ZP_X;
        base_len = oat_pkg::LEN_TWO;
      end
      oat_pkg::oat_m_zp_y: begin
        base_cyc = oat_pkg::CYC_ZP_Y;
        base_len = oat_pkg::LEN_TWO;
      end
      oat_pkg::oat_m_zp_ind: begin
        base_cyc = oat_pkg::CYC_ZP_IND;
        base_len = oat_pkg::LEN_TWO;
      end
      oat_pkg::oat_m_zp_ind_y: begin
        base_cyc = oat_pkg::CYC_ZP_IND_Y;
        base_len = oat_pkg::LEN_TWO;
      end
      oat_pkg::oat_m_break: begin
        // Signature byte is skipped but counted
        base_cyc = oat_pkg::CYC_BREAK;
        base_len = oat_pkg::LEN_TWO;
      end
      oat_pkg::oat_m_stack: begin
        base_cyc = oat_pkg::CYC_ZP;
        base_len = oat_pkg::LEN_ONE;
      end
      default: begin
        // Accumulator and implied forms
        base_cyc = oat_pkg::CYC_TWO;
        base_len = oat_pkg::LEN_ONE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Adder operand select
  // ---------------------------------------------------------------
  // Index step adds X or Y to the page zero byte or base low byte;
  // pointer step bumps the pointer for its high byte.
  always_comb begin
    add_a = zp_r;
    add_b = x_r;
    case (state_r)
      oat_s_index: begin
        // Post index adds Y to the fetched base low byte, not to the pointer
        add_a = (mode_r == oat_pkg::oat_m_zp_ind_y) ? ptr_lo_r : zp_r;
        if (mode_r == oat_pkg::oat_m_zp_y || mode_r == oat_pkg::oat_m_abs_y ||
            mode_r == oat_pkg::oat_m_zp_ind_y) begin
          add_b = y_r;
        end else begin
          add_b = x_r;
        end
      end
      oat_s_ptr_lo: begin
        add_a = zp_r;
        add_b = oat_pkg::PTR_STEP;
      end
      default: begin
        add_a = zp_r;
        add_b = x_r;
      end
    endcase
  end

  oat_add8 u_add (
    .clk(clk),
    .rstn(rstn),
    .a(add_a),
    .b(add_b),
    .sum_r(add_sum),
    .carry_r(add_carry)
  );

  // ---------------------------------------------------------------
  // Branch destination and page check
  // ---------------------------------------------------------------
  // Offset is signed and counted from the byte after the branch
  assign br_target = pc_r + 16'(oat_pkg::LEN_TWO) + {{8{zp_r[7]}}, zp_r};
  assign br_cross = br_target[15:8] != hi_r;

  // ---------------------------------------------------------------
  // Final address and cycle count
  // ---------------------------------------------------------------
  always_comb begin
    eff_nxt = {hi_r, zp_r};
    cyc_nxt = base_cyc;
    case (mode_r)
      oat_pkg::oat_m_zp_x, oat_pkg::oat_m_zp_y, oat_pkg::oat_m_zp_ind_x: begin
        eff_nxt = {oat_pkg::PAGE_ZERO, zp_r};
      end
      oat_pkg::oat_m_zp: begin
        eff_nxt = {oat_pkg::PAGE_ZERO, zp_r};
      end
      oat_pkg::oat_m_abs_x, oat_pkg::oat_m_abs_y: begin
        eff_nxt = {hi_r + {7'h00, taken_r}, zp_r};
        if (taken_r || (sta_r && mode_r == oat_pkg::oat_m_abs_x)) begin
          cyc_nxt = base_cyc + oat_pkg::CYC_ONE;
        end
      end
      oat_pkg::oat_m_zp_ind_y: begin
        eff_nxt = {hi_r + {7'h00, taken_r}, zp_r};
        if (taken_r) begin
          cyc_nxt = base_cyc + oat_pkg::CYC_ONE;
        end
      end
      oat_pkg::oat_m_rel: begin
        eff_nxt = taken_r ? br_target : pc_r + 16'(oat_pkg::LEN_TWO);
        if (taken_r) begin
          cyc_nxt = base_cyc + oat_pkg::CYC_ONE + (br_cross ? oat_pkg::CYC_ONE : 4'h0);
        end
      end
      default: begin
        eff_nxt = {hi_r, zp_r};
      end
    endcase
    if (rmw_r) begin
      cyc_nxt = cyc_nxt + oat_pkg::CYC_RMW;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Capture at start, step through index and pointer fetches.
  // The adder is registered, so each step reads last cycle's sum.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= oat_s_idle;
      mode_r <= oat_pkg::oat_m_impl;
      zp_r <= 8'h00;
      hi_r <= 8'h00;
      x_r <= 8'h00;
      y_r <= 8'h00;
      ptr_lo_r <= 8'h00;
      pc_r <= 16'h0000;
      rmw_r <= 1'b0;
      sta_r <= 1'b0;
      taken_r <= 1'b0;
    end else begin
      case (state_r)
        oat_s_idle: begin
          if (start) begin
            mode_r <= mode;
            zp_r <= operand_lo;
            hi_r <= operand_hi;
            x_r <= index_x;
            y_r <= index_y;
            pc_r <= pc_opcode;
            rmw_r <= is_rmw;
            sta_r <= is_store_accumulator;
            taken_r <= 1'b0;
            case (mode)
              oat_pkg::oat_m_zp_x, oat_pkg::oat_m_zp_y, oat_pkg::oat_m_zp_ind_x,
              oat_pkg::oat_m_abs_x, oat_pkg::oat_m_abs_y: state_r <= oat_s_index;
              oat_pkg::oat_m_zp_ind, oat_pkg::oat_m_zp_ind_y: state_r <= oat_s_ptr_lo;
              oat_pkg::oat_m_rel: begin
                taken_r <= branch_taken;
                hi_r <= pc_opcode[15:8] + 8'(pc_opcode[7:0] > 8'hfd);
                state_r <= oat_s_finish;
              end
              default: state_r <= oat_s_finish;
            endcase
          end
        end
        oat_s_index: begin
          state_r <= oat_s_post;
        end
        oat_s_ptr_lo: begin
          // Pointer low byte is on the bus this cycle
          ptr_lo_r <= mem_rdata;
          state_r <= oat_s_ptr_hi;
        end
        oat_s_ptr_hi: begin
          // High byte read at pointer plus one, carry dropped
          hi_r <= mem_rdata;
          if (mode_r == oat_pkg::oat_m_zp_ind) begin
            zp_r <= ptr_lo_r;
            state_r <= oat_s_finish;
          end else begin
            state_r <= oat_s_index;
          end
        end
        oat_s_post: begin
          // Sum lands; carry kept only for the sixteen-bit forms
          zp_r <= add_sum;
          if (mode_r == oat_pkg::oat_m_abs_x || mode_r == oat_pkg::oat_m_abs_y ||
              mode_r == oat_pkg::oat_m_zp_ind_y) begin
            taken_r <= add_carry;
          end
          state_r <= oat_s_finish;
        end
        default: begin
          state_r <= oat_s_idle;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Memory address for pointer fetches
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mem_addr_r <= 16'h0000;
      mem_rd_r <= 1'b0;
    end else if (state_r == oat_s_idle && start &&
                 (mode == oat_pkg::oat_m_zp_ind || mode == oat_pkg::oat_m_zp_ind_y)) begin
      mem_addr_r <= {oat_pkg::PAGE_ZERO, operand_lo};
      mem_rd_r <= 1'b1;
    end else if (state_r == oat_s_ptr_lo) begin
      mem_addr_r <= {oat_pkg::PAGE_ZERO, zp_r + oat_pkg::PTR_STEP};
      mem_rd_r <= 1'b1;
    end else begin
      mem_rd_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Result outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      done_r <= 1'b0;
      busy_r <= 1'b0;
      eff_addr_r <= 16'h0000;
      cycles_r <= 4'h0;
      length_r <= 2'h0;
      next_pc_r <= 16'h0000;
      return_pc_r <= 16'h0000;
    end else begin
      done_r <= state_r == oat_s_finish;
      busy_r <= (state_r == oat_s_idle) ? start : (state_r != oat_s_finish);
      if (state_r == oat_s_finish) begin
        eff_addr_r <= eff_nxt;
        cycles_r <= cyc_nxt;
        length_r <= base_len;
        next_pc_r <= pc_r + 16'(base_len);
        if (mode_r == oat_pkg::oat_m_break) begin
          return_pc_r <= pc_r + 16'(oat_pkg::LEN_TWO);
        end
      end
    end
  end
endmodule : oat_top

// ---- testbench/oat_mem_model.sv ----
`timescale 1ns/10ps
// Page zero memory seen by the pointer fetches
module oat_mem_model (
  // Clock
  input wire logic clk,
  // Fetch request
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  // Read data
  output logic [7:0] mem_rdata
);
  // Last byte shown, so an idle bus never repeats it
  logic [7:0] last_r = 8'h00;
  // Content is a fixed pattern of the address; idle shows a toggling value
  always_comb begin
    mem_rdata = mem_rd ? mem_addr[7:0] + 8'h31 : ~last_r;
  end
  // Remember what was on the bus
  always_ff @(posedge clk) begin
    last_r <= mem_rdata;
  end
endmodule : oat_mem_model

// ---- testbench/oat_top_properties.sv ----
`timescale 1ns/10ps
// Timing and address checks at the ports of the block
module oat_top_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Request
  input wire logic start,
  input wire oat_pkg::oat_mode_t mode,
  input wire logic [7:0] operand_lo,
  input wire logic [7:0] index_x,
  input wire logic [7:0] index_y,
  input wire logic [15:0] pc_opcode,
  input wire logic is_rmw,
  input wire logic is_store_accumulator,
  input wire logic branch_taken,
  // Results
  input wire logic [15:0] mem_addr_r,
  input wire logic mem_rd_r,
  input wire logic done_r,
  input wire logic busy_r,
  input wire logic [15:0] eff_addr_r,
  input wire logic [3:0] cycles_r,
  input wire logic [1:0] length_r,
  input wire logic [15:0] next_pc_r,
  input wire logic [15:0] return_pc_r
);
  // Request accepted this edge
  logic take;
  assign take = start && !busy_r;
  // Copy of the request, held until its done pulse
  oat_pkg::oat_mode_t mode_r;
  logic [7:0] lo_r, x_r, y_r;
  logic [15:0] pc_r;
  logic rmw_r, sta_r, br_r;
  // Capture only on acceptance; ignored starts must not disturb the copy
  always_ff @(posedge clk) begin
    if (take) begin
      mode_r <= mode;
      lo_r <= operand_lo;
      x_r <= index_x;
      y_r <= index_y;
      pc_r <= pc_opcode;
      rmw_r <= is_rmw;
      sta_r <= is_store_accumulator;
      br_r <= branch_taken;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Pointer low byte fetch, then high byte with wrap
  sequence s_ptr_lo;
    mem_rd_r && mem_addr_r == {8'h00, lo_r};
  endsequence
  sequence s_ptr_hi;
    mem_rd_r && mem_addr_r == {8'h00, lo_r + 8'h01};
  endsequence
  property p_ptr_fetch;
    take && (mode == oat_pkg::oat_m_zp_ind || mode == oat_pkg::oat_m_zp_ind_y) |=>
      s_ptr_lo ##1 s_ptr_hi;
  endproperty
  a_ptr_fetch: assert property (p_ptr_fetch) else $error("pointer fetch wrong");
  property p_zpx_time;
    take && mode == oat_pkg::oat_m_zp_x |=> !done_r [*3] ##1
      (done_r && cycles_r == (rmw_r ? 4'h6 : 4'h4) && length_r == 2'h2);
  endproperty
  a_zpx_time: assert property (p_zpx_time) else $error("zp x timing wrong");
  property p_zpx_addr;
    done_r && mode_r == oat_pkg::oat_m_zp_x |-> eff_addr_r == {8'h00, lo_r + x_r};
  endproperty
  a_zpx_addr: assert property (p_zpx_addr) else $error("zp x address wrong");
  property p_zpy;
    done_r && mode_r == oat_pkg::oat_m_zp_y && !rmw_r |->
      eff_addr_r == {8'h00, lo_r + y_r} && cycles_r == 4'h4;
  endproperty
  a_zpy: assert property (p_zpy) else $error("zp y result wrong");
  property p_zpi_time;
    take && mode == oat_pkg::oat_m_zp_ind && !is_rmw |->
      ##4 done_r && cycles_r == 4'h5 && length_r == 2'h2;
  endproperty
  a_zpi_time: assert property (p_zpi_time) else $error("zp indirect timing wrong");
  property p_zpiy_cyc;
    done_r && mode_r == oat_pkg::oat_m_zp_ind_y && !rmw_r |->
      cycles_r == ((eff_addr_r[7:0] < y_r) ? 4'h6 : 4'h5);
  endproperty
  a_zpiy_cyc: assert property (p_zpiy_cyc) else $error("post index cycles wrong");
  // Post index: two fetches, index step and sum land before the done pulse
  property p_zpiy_time;
    take && mode == oat_pkg::oat_m_zp_ind_y |=> !done_r [*5] ##1 (done_r && length_r == 2'h2);
  endproperty
  a_zpiy_time: assert property (p_zpiy_time) else $error("post index time wrong");
  property p_abs;
    done_r && mode_r == oat_pkg::oat_m_abs && !rmw_r |-> cycles_r == 4'h4 && length_r == 2'h3;
  endproperty
  a_abs: assert property (p_abs) else $error("absolute timing wrong");
  property p_sta;
    done_r && mode_r == oat_pkg::oat_m_abs_x && sta_r && !rmw_r |-> cycles_r == 4'h5;
  endproperty
  a_sta: assert property (p_sta) else $error("store penalty wrong");
  property p_branch;
    done_r && mode_r == oat_pkg::oat_m_rel |-> length_r == 2'h2 &&
      cycles_r >= (br_r ? 4'h3 : 4'h2) && cycles_r <= (br_r ? 4'h4 : 4'h2);
  endproperty
  a_branch: assert property (p_branch) else $error("branch timing wrong");
  property p_break;
    done_r && mode_r == oat_pkg::oat_m_break |-> length_r == 2'h2 &&
      next_pc_r == pc_r + 16'h0002 && return_pc_r == pc_r + 16'h0002;
  endproperty
  a_break: assert property (p_break) else $error("break length wrong");
  property p_ind_jump;
    done_r && !rmw_r && (mode_r == oat_pkg::oat_m_abs_ind || mode_r == oat_pkg::oat_m_abs_ind_x)
      |-> cycles_r == 4'h6 && length_r == 2'h3;
  endproperty
  a_ind_jump: assert property (p_ind_jump) else $error("jump timing wrong");
  property p_zpix;
    done_r && mode_r == oat_pkg::oat_m_zp_ind_x && !rmw_r |-> cycles_r == 4'h6 && length_r == 2'h2;
  endproperty
  a_zpix: assert property (p_zpix) else $error("pre index timing wrong");
endmodule : oat_top_properties

// ---- testbench/oat_top_tb.sv ----
`timescale 1ns/10ps
bind oat_top oat_top_properties u_props (.clk(clk), .rstn(rstn), .start(start), .mode(mode),
  .operand_lo(operand_lo), .index_x(index_x), .index_y(index_y), .pc_opcode(pc_opcode),
  .is_rmw(is_rmw), .is_store_accumulator(is_store_accumulator), .branch_taken(branch_taken),
  .mem_addr_r(mem_addr_r), .mem_rd_r(mem_rd_r), .done_r(done_r), .busy_r(busy_r),
  .eff_addr_r(eff_addr_r), .cycles_r(cycles_r), .length_r(length_r), .next_pc_r(next_pc_r),
  .return_pc_r(return_pc_r));
module oat_top_tb;
  // Stimulus and observed results
  logic clk = 1'b0;
  logic rstn, start, rmw, store_accumulator, br;
  oat_pkg::oat_mode_t mode;
  logic [7:0] lo, hi, x, y, rdata;
  logic [15:0] pc, addr, eff, npc, rpc;
  logic rd, done, busy;
  logic [3:0] cyc;
  logic [1:0] len;
  int mismatches = 0;
  int comparisons = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  // Block under test and its page zero memory
  oat_top DUT (.clk(clk), .rstn(rstn), .start(start), .mode(mode), .operand_lo(lo),
    .operand_hi(hi), .index_x(x), .index_y(y), .pc_opcode(pc), .is_rmw(rmw),
    .is_store_accumulator(store_accumulator), .branch_taken(br), .mem_rdata(rdata), .mem_addr_r(addr),
    .mem_rd_r(rd), .done_r(done), .busy_r(busy), .eff_addr_r(eff), .cycles_r(cyc),
    .length_r(len), .next_pc_r(npc), .return_pc_r(rpc));
  oat_mem_model u_mem (.clk(clk), .mem_addr(addr), .mem_rd(rd), .mem_rdata(rdata));
  // Memory pattern, kept apart from the model's own code
  function automatic logic [7:0] mem_f(input logic [7:0] a);
    return a + 8'h31;
  endfunction : mem_f
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  // Single compare for every result, padded to 16 bits
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // One request, flags are {rmw, store, taken}; waits for done under a bound
  task automatic one(input oat_pkg::oat_mode_t m, input logic [7:0] l, input logic [7:0] h,
      input logic [7:0] xi, input logic [7:0] yi, input logic [2:0] f, input bit ce,
      input logic [15:0] e_eff, input logic [3:0] e_cyc, input logic [1:0] e_len);
    int n;
    @(posedge clk);
    start <= 1'b1;
    mode <= m;
    lo <= l;
    hi <= h;
    x <= xi;
    y <= yi;
    {rmw, store_accumulator, br} <= f;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 20);
    chk("done", 16'h0001, {15'h0000, done});
    chk("busy", 16'h0000, {15'h0000, busy});
    if (ce) chk("eff_addr", e_eff, eff);
    chk("cycles", {12'h000, e_cyc}, {12'h000, cyc});
    chk("length", {14'h0000, e_len}, {14'h0000, len});
    chk("next_pc", pc + {14'h0000, e_len}, npc);
  endtask : one
  // Indexed page zero forms; zp,x and zp,y wrap inside page zero
  task automatic t_zp_x();
    one(oat_pkg::oat_m_zp_x, 8'hf0, 8'h00, 8'h20, 8'h00, 3'b000, 1, 16'h0010, 4'h4, 2'h2);
    one(oat_pkg::oat_m_zp_x, 8'hf0, 8'h00, 8'h20, 8'h00, 3'b100, 1,
      16'h0010, 4'h6, 2'h2);
    one(oat_pkg::oat_m_zp_y, 8'h80, 8'h00, 8'h00, 8'h90, 3'b000, 1, 16'h0010, 4'h4, 2'h2);
    one(oat_pkg::oat_m_zp_ind_x, 8'h70, 8'h00, 8'h05, 8'h00, 3'b000, 1,
      16'h0075, 4'h6, 2'h2);
  endtask : t_zp_x
  // Pointer at the top of page zero: high byte comes from address zero
  task automatic t_zp_ind();
    one(oat_pkg::oat_m_zp_ind, 8'hff, 8'h00, 8'h00, 8'h00, 3'b000, 1,
      {mem_f(8'h00), mem_f(8'hff)}, 4'h5, 2'h2);
  endtask : t_zp_ind
  // Post index with and without a page crossing
  task automatic t_zp_ind_y();
    one(oat_pkg::oat_m_zp_ind_y, 8'h10, 8'h00, 8'h00, 8'hc0, 3'b000, 1,
      {mem_f(8'h11), mem_f(8'h10)} + 16'h00c0, 4'h6, 2'h2);
    one(oat_pkg::oat_m_zp_ind_y, 8'h10, 8'h00, 8'h00, 8'h01, 3'b000, 1,
      {mem_f(8'h11), mem_f(8'h10)} + 16'h0001, 4'h5, 2'h2);
  endtask : t_zp_ind_y
  // Three byte forms
  task automatic t_abs();
    one(oat_pkg::oat_m_abs, 8'h34, 8'h12, 8'h00, 8'h00, 3'b000, 1, 16'h1234, 4'h4, 2'h3);
    one(oat_pkg::oat_m_abs, 8'h34, 8'h12, 8'h00, 8'h00, 3'b100, 1, 16'h1234, 4'h6, 2'h3);
    one(oat_pkg::oat_m_abs_x, 8'h34, 8'h12, 8'hf0, 8'h00, 3'b000, 1,
      16'h1324, 4'h5, 2'h3);
    one(oat_pkg::oat_m_abs_y, 8'h34, 8'h12, 8'h00, 8'h01, 3'b000, 1,
      16'h1235, 4'h4, 2'h3);
    one(oat_pkg::oat_m_abs_x, 8'h34, 8'h12, 8'h01, 8'h00, 3'b010, 1,
      16'h1235, 4'h5, 2'h3);
    one(oat_pkg::oat_m_abs_ind, 8'h34, 8'h12, 8'h00, 8'h00, 3'b000, 1,
      16'h1234, 4'h6, 2'h3);
    one(oat_pkg::oat_m_abs_ind_x, 8'h34, 8'h12, 8'h02, 8'h00, 3'b000, 1,
      16'h1234, 4'h6, 2'h3);
  endtask : t_abs
  // Branch not taken, taken within the page, and taken back into the page below
  task automatic t_rel();
    one(oat_pkg::oat_m_rel, 8'h10, 8'h00, 8'h00, 8'h00, 3'b000, 1,
      16'h0202, 4'h2, 2'h2);
    one(oat_pkg::oat_m_rel, 8'h10, 8'h00, 8'h00, 8'h00, 3'b001, 1,
      16'h0212, 4'h3, 2'h2);
    one(oat_pkg::oat_m_rel, 8'h80, 8'h00, 8'h00, 8'h00, 3'b001, 1,
      16'h0182, 4'h4, 2'h2);
  endtask : t_rel
  // Break across a page edge: both counters skip the signature byte
  task automatic t_break();
    @(posedge clk);
    pc <= 16'h30fe;
    one(oat_pkg::oat_m_break, 8'h00, 8'h00, 8'h00, 8'h00, 3'b000, 0, 16'h0, 4'h7, 2'h2);
    chk("return_pc", 16'h3100, rpc);
  endtask : t_break
  // Main sequence
  initial begin
    rstn = 1'b0;
    start = 1'b0;
    mode = oat_pkg::oat_m_abs;
    {lo, hi, x, y} = 32'h0000_0000;
    {rmw, store_accumulator, br} = 3'b000;
    pc = 16'h0200;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_zp_x();
    t_zp_ind();
    t_zp_ind_y();
    t_abs();
    t_rel();
    t_break();
    summarize();
  end
  // About 20 requests of under 20 cycles each; allow ten times that
  initial begin
    #40000;
    mismatches++;
    summarize();
  end
endmodule : oat_top_tb
